// *** logic/mcid_core_decode.sv ***
`timescale 1ns/1ps
`include "mcid_regs.svh"
module mcid_core_decode (
  input  wire logic                    clock,
  input  wire logic                    reset,
  input  wire logic [12:0]             cfg_word,
  input  wire logic [12:0]             id_word,
  input  wire logic [12:0]             instr_rdata,
  input  wire logic                    skip_true,
  input  wire logic                    watchdog_timeout,
  input  wire logic                    wake_pin,
  output logic                         fetch_strobe,
  output logic                         timer_counter_tick,
  output logic                         exec_valid,
  output mcid_pkg::mcid_kind_e         op_kind,
  output logic [12:0]                  instr_word,
  output logic [3:0]                   alu_op,
  output logic                         dest_is_reg,
  output logic [5:0]                   reg_sel,
  output logic [2:0]                   bit_sel,
  output logic [1:0]                   bit_action,
  output logic [7:0]                   lit8,
  output logic [9:0]                   pc_load_addr,
  output logic                         pc_push,
  output logic                         writes_pc,
  output logic                         is_skip,
  output logic                         keep_pc_page,
  output logic                         upd_zero,
  output logic                         upd_carry,
  output logic                         upd_dcarry,
  output logic [3:0]                   ctrl_index,
  output logic                         ctrl_valid,
  output logic                         sleep_instr,
  output logic                         watchdog_clear_instr,
  output logic                         global_irq_on_instr,
  output logic                         global_irq_off_instr,
  output logic                         return_irq_instr,
  output logic                         osc_stop,
  output logic                         time_out_flag,
  output logic                         power_down_flag,
  output logic                         instr_period_select,
  output logic                         watchdog_enable,
  output logic                         clock_source_type,
  output logic                         crystal_range_select,
  output logic                         drive_power_select,
  output logic                         code_protect_en,
  output logic                         cfg_reserved_err,
  output logic [12:0]                  customer_id
);
  import mcid_pkg::*;

  // configuration, loaded once after reset; no instruction path reaches it
  logic [12:0] cfg_r;
  logic [12:0] id_r;
  logic        cfg_loaded_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_r        <= `MCID_CFG_RESET;
      id_r         <= 13'h0_000;
      cfg_loaded_r <= 1'b0;
    end else if (!cfg_loaded_r) begin
      cfg_r        <= cfg_word;
      id_r         <= id_word;
      cfg_loaded_r <= 1'b1;
    end
  end

  assign instr_period_select  = cfg_r[`MCID_CFG_PERIOD];
  assign watchdog_enable      = ~cfg_r[`MCID_CFG_WDT_OFF];
  assign clock_source_type    = cfg_r[`MCID_CFG_SRC];
  assign crystal_range_select = cfg_r[`MCID_CFG_SRC] & cfg_r[`MCID_CFG_XRANGE];
  assign drive_power_select   = cfg_r[`MCID_CFG_POWER];
  assign code_protect_en      = (cfg_r[2:0] != `MCID_PROT_OFF);
  assign customer_id          = id_r;
  // flags an image that breaks the reserved-bit or RC-range convention
  assign cfg_reserved_err = ~cfg_r[`MCID_CFG_RSV_HI] | ~cfg_r[`MCID_CFG_RSV_MID]
                          | cfg_r[`MCID_CFG_RSV_LO]
                          | (~cfg_r[`MCID_CFG_SRC] & cfg_r[`MCID_CFG_XRANGE]);

  // instruction cycle timing
  logic cyc_start;
  logic cyc_end;

  mcid_period_timer u_timer (
    .clock       (clock),
    .reset       (reset),
    .four_period (instr_period_select),
    .cycle_start (cyc_start),
    .cycle_end   (cyc_end)
  );

  mcid_state_e state_r;
  mcid_state_e state_nxt;
  logic [1:0]  wake_sync_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      wake_sync_r <= 2'b00;
    end else begin
      wake_sync_r <= {wake_sync_r[0], wake_pin};
    end
  end

  assign fetch_strobe       = cyc_start & cfg_loaded_r & (state_r != MCID_ST_SLEEP);
  // timer clock is fosc/2 or fosc/4 following the cycle length, halted in sleep
  assign timer_counter_tick = cyc_end & (state_r != MCID_ST_SLEEP);
  assign osc_stop           = (state_r == MCID_ST_SLEEP);

  // decode of the word arriving from program memory
  wire [12:0] w       = instr_rdata;
  wire [5:0]  w_reg   = w[5:0];
  wire [3:0]  w_aop   = w[10:7];
  wire [2:0]  w_lop   = w[10:8];
  wire        d_zgrp  = (w[12:4] == 9'h000);
  wire        d_ogrp  = (w[12:4] == 9'h001);
  wire        d_sleep = (w == `MCID_OP_SLEEP);
  wire        d_watchdog_clear_instr  = (w == `MCID_OP_WATCHDOG_CLEAR_INSTR);
  wire        d_ion   = (w == `MCID_OP_IRQ_ON);
  wire        d_ioff  = (w == `MCID_OP_IRQ_OFF);
  wire        d_ret   = (w == `MCID_OP_RET);
  wire        d_return_irq_instr  = (w == `MCID_OP_RETURN_IRQ_INSTR);
  wire        d_misc  = (w == `MCID_OP_NOP) | (w == `MCID_OP_DAA)
                      | (w == `MCID_OP_CONTW) | (w == `MCID_OP_CONTR);
  wire        d_iow   = d_zgrp & (w[3:0] >= `MCID_CTRL_MIN);
  wire        d_ior   = d_ogrp & (w[3:0] >= `MCID_CTRL_MIN);
  wire        d_tbl   = (w == `MCID_OP_TBL);
  wire        d_movra = (w[12:6] == 7'h01);
  wire        d_clra  = (w == `MCID_OP_CLRA);
  wire        d_clrr  = (w[12:6] == 7'h03);
  wire        d_alu   = (w[12:11] == 2'b00) & (w[10:8] != 3'h0);
  wire        d_bit   = (w[12:11] == 2'b01);
  wire        d_call  = (w[12:10] == 3'b100);
  wire        d_jmp   = (w[12:10] == 3'b101);
  wire        d_swi   = (w == `MCID_OP_SWI);
  wire        d_lit   = (w[12:11] == 2'b11) & ~d_swi & (w_lop != 3'h6);
  wire        d_retl  = d_lit & (w_lop == 3'h4);
  wire        d_sys   = d_sleep | d_watchdog_clear_instr | d_ion | d_ioff | d_return_irq_instr | d_swi;
  wire        d_ctrlv = (w[3:0] == 4'h5) | (w[3:0] == 4'h6) | (w[3:0] == 4'h7)
                      | (w[3:0] == 4'hB) | (w[3:0] == 4'hE) | (w[3:0] == 4'hF);

  wire d_zcd   = (d_alu & ((w_aop == 4'h2) | (w_aop == 4'h7))) | d_tbl
               | (d_lit & ((w_lop == 3'h5) | (w_lop == 3'h7)));
  wire d_zonly = (d_alu & ((w_aop == 4'h3) | (w_aop == 4'h4) | (w_aop == 4'h5)
               | (w_aop == 4'h6) | (w_aop == 4'h8) | (w_aop == 4'h9) | (w_aop == 4'hA)))
               | d_clra | d_clrr | (d_lit & (w_lop >= 3'h1) & (w_lop <= 3'h3));
  wire d_conly = (w == `MCID_OP_DAA) | (d_alu & ((w_aop == 4'hC) | (w_aop == 4'hD)));
  wire d_skip  = (d_alu & ((w_aop == 4'hB) | (w_aop == 4'hF))) | (d_bit & w[10]);
  // any write landing on the program counter register costs a second cycle
  wire d_pcw   = d_tbl | ((w_reg == `MCID_PC_REG)
               & ((d_alu & w[6]) | d_movra | d_clrr | (d_bit & ~w[10])));
  wire d_brch  = d_call | d_jmp | d_ret | d_return_irq_instr | d_retl | d_swi;

  mcid_kind_e d_kind;
  always_comb begin
    d_kind = MCID_K_NONE;
    if (d_sys)                d_kind = MCID_K_SYS;
    else if (d_misc)          d_kind = MCID_K_MISC;
    else if (d_ret)           d_kind = MCID_K_RET;
    else if (d_iow)           d_kind = MCID_K_IOW;
    else if (d_ior)           d_kind = MCID_K_IOR;
    else if (d_tbl)           d_kind = MCID_K_TBL;
    else if (d_movra)         d_kind = MCID_K_MOVRA;
    else if (d_clra | d_clrr) d_kind = MCID_K_CLR;
    else if (d_alu)           d_kind = MCID_K_ALU;
    else if (d_bit)           d_kind = MCID_K_BIT;
    else if (d_call)          d_kind = MCID_K_CALL;
    else if (d_jmp)           d_kind = MCID_K_JMP;
    else if (d_retl)          d_kind = MCID_K_RET;
    else if (d_lit)           d_kind = MCID_K_LIT;
  end

  // sequencing: one cycle per instruction, a bubble after two-cycle ones
  logic static_two_r;
  logic sleep_instr_r;
  wire  two_cycle = static_two_r | (is_skip & skip_true);
  wire  load_now  = cyc_end & cfg_loaded_r & ((state_r == MCID_ST_IDLE)
                  | (state_r == MCID_ST_FLUSH)
                  | ((state_r == MCID_ST_EXEC) & ~two_cycle & ~sleep_instr_r));

  always_comb begin
    case (state_r)
      MCID_ST_IDLE:  state_nxt = load_now ? MCID_ST_EXEC : MCID_ST_IDLE;
      MCID_ST_EXEC: begin
        if (!cyc_end)         state_nxt = MCID_ST_EXEC;
        else if (sleep_instr_r) state_nxt = MCID_ST_SLEEP;
        else if (two_cycle)   state_nxt = MCID_ST_FLUSH;
        else                  state_nxt = MCID_ST_EXEC;
      end
      MCID_ST_FLUSH: state_nxt = cyc_end ? MCID_ST_EXEC : MCID_ST_FLUSH;
      MCID_ST_SLEEP: state_nxt = wake_sync_r[1] ? MCID_ST_IDLE : MCID_ST_SLEEP;
      default:       state_nxt = MCID_ST_IDLE;
    endcase
  end

  logic       exec_valid_r;
  mcid_kind_e kind_r;
  logic [12:0] word_r;
  logic       is_skip_r;
  logic       writes_pc_r;
  logic       pc_push_r;
  logic [9:0] pc_addr_r;
  logic [2:0] upd_r;
  logic       ctrl_valid_r;
  logic [4:0] pulse_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r      <= MCID_ST_IDLE;
      exec_valid_r <= 1'b0;
      kind_r       <= MCID_K_NONE;
      word_r       <= 13'h0_000;
      static_two_r <= 1'b0;
      is_skip_r    <= 1'b0;
      writes_pc_r  <= 1'b0;
      pc_push_r    <= 1'b0;
      pc_addr_r    <= 10'h000;
      upd_r        <= 3'h0;
      ctrl_valid_r <= 1'b0;
      sleep_instr_r <= 1'b0;
      pulse_r      <= 5'h00;
    end else begin
      state_r <= state_nxt;
      pulse_r <= load_now ? {d_sleep, d_watchdog_clear_instr, d_ion, d_ioff, d_return_irq_instr} : 5'h00;
      if (load_now) begin
        exec_valid_r  <= 1'b1;
        kind_r        <= d_kind;
        word_r        <= w;
        static_two_r  <= d_pcw | d_brch;
        is_skip_r     <= d_skip;
        writes_pc_r   <= d_pcw;
        pc_push_r     <= d_call | d_swi;
        pc_addr_r     <= d_swi ? `MCID_SWI_VECTOR : w[9:0];
        upd_r         <= {d_zcd | d_zonly, d_zcd | d_conly, d_zcd};
        ctrl_valid_r  <= (d_iow | d_ior) & d_ctrlv;
        sleep_instr_r <= d_sleep;
      end else if (cyc_end) begin
        exec_valid_r  <= 1'b0;
        kind_r        <= MCID_K_NONE;
        static_two_r  <= 1'b0;
        is_skip_r     <= 1'b0;
        writes_pc_r   <= 1'b0;
        pc_push_r     <= 1'b0;
        upd_r         <= 3'h0;
        ctrl_valid_r  <= 1'b0;
        sleep_instr_r <= 1'b0;
      end
    end
  end

  // power-down status: timeout clears T, sleep clears P, clear-watchdog sets both
  logic tflag_r;
  logic pflag_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      tflag_r <= 1'b1;
      pflag_r <= 1'b1;
    end else begin
      if (watchdog_timeout)                tflag_r <= 1'b0;
      else if (pulse_r[4] | pulse_r[3])    tflag_r <= 1'b1;
      if (pulse_r[4])                      pflag_r <= 1'b0;
      else if (pulse_r[3])                 pflag_r <= 1'b1;
    end
  end

  assign exec_valid           = exec_valid_r;
  assign op_kind              = kind_r;
  assign instr_word           = word_r;
  assign alu_op               = word_r[10:7];
  assign dest_is_reg          = word_r[6];
  assign reg_sel              = word_r[5:0];
  assign bit_sel              = word_r[8:6];
  assign bit_action           = word_r[10:9];
  assign lit8                 = word_r[7:0];
  assign pc_load_addr         = pc_addr_r;
  assign pc_push              = pc_push_r;
  assign writes_pc            = writes_pc_r;
  assign is_skip              = is_skip_r;
  assign keep_pc_page         = (kind_r == MCID_K_TBL);
  assign upd_zero             = upd_r[2];
  assign upd_carry            = upd_r[1];
  assign upd_dcarry           = upd_r[0];
  assign ctrl_index           = word_r[3:0];
  assign ctrl_valid           = ctrl_valid_r;
  assign sleep_instr          = pulse_r[4];
  assign watchdog_clear_instr = pulse_r[4] | pulse_r[3];
  assign global_irq_on_instr  = pulse_r[2] | pulse_r[0];
  assign global_irq_off_instr = pulse_r[1];
  assign return_irq_instr     = pulse_r[0];
  assign time_out_flag        = tflag_r;
  assign power_down_flag      = pflag_r;
endmodule // mcid_core_decode

// *** logic/mcid_regs.svh ***
// Overview of operation
// - Instructions are fetched and decoded as 13-bit words: opcode plus operand fields.
// - By default an ordinary instruction takes one cycle of two oscillator periods.
// - Any instruction writing the program counter register takes two instruction cycles.
// - Jump, call, returns and true conditional skips take two instruction cycles.
// - Config bit 8 picks two (0) or four (1) oscillator periods per cycle.
// - With four-period cycles the timer counter clock is oscillator divided by four.
// - Configuration word is outside program memory; program code cannot read or write it.
// - Config bit 7 enables the watchdog when zero, disables it when one.
// - Config bit 5 picks low/high crystal range; only meaningful for crystal type.
// - Config bit 4 selects RC oscillator when zero, crystal when one.
// - Config bit 3 selects low oscillator power when zero, high when one.
// - Protect bits 2..0 enable code protection unless all three are one.
// - A second word holds a 13-bit customer identification value.
// - Table jump adds accumulator to program counter, updates Z, C, DC, keeps bits 9..8.
// - Register operand instructions take a register designator from the low word bits.
// - Bit instructions decode a three-bit field choosing the bit to set, clear, test.
// - Literals are 8 bits for data operations and 10 bits for jump and call.
// - Any bit of any register can be set, cleared or tested by one instruction.
// - I/O registers are addressed as general registers by the same instructions.
// - Control register write/read address only control registers 5-7, B, E, F.
// - Software interrupt pushes incremented program counter and continues at address 002H.
`ifndef MCID_REGS_SVH
`define MCID_REGS_SVH

`define MCID_WORD_W        13
`define MCID_CFG_PERIOD    8
`define MCID_CFG_WDT_OFF   7
`define MCID_CFG_XRANGE    5
`define MCID_CFG_SRC       4
`define MCID_CFG_POWER     3
`define MCID_CFG_RSV_HI    12
`define MCID_CFG_RSV_MID   11
`define MCID_CFG_RSV_LO    9
`define MCID_CFG_RESET     13'h1_DFF
`define MCID_PROT_OFF      3'h7

`define MCID_OSC_PER_NS    10
`define MCID_SHORT_PERIODS 2
`define MCID_LONG_PERIODS  4
`define MCID_SHORT_LAST    2'h1
`define MCID_LONG_LAST     2'h3

`define MCID_OP_NOP        13'h0_000
`define MCID_OP_DAA        13'h0_001
`define MCID_OP_CONTW      13'h0_002
`define MCID_OP_SLEEP      13'h0_003
`define MCID_OP_WATCHDOG_CLEAR_INSTR       13'h0_004
`define MCID_OP_IRQ_ON     13'h0_010
`define MCID_OP_IRQ_OFF    13'h0_011
`define MCID_OP_RET        13'h0_012
`define MCID_OP_RETURN_IRQ_INSTR       13'h0_013
`define MCID_OP_CONTR      13'h0_014
`define MCID_OP_TBL        13'h0_020
`define MCID_OP_CLRA       13'h0_080
`define MCID_OP_SWI        13'h1_E02
`define MCID_PC_REG        6'h02
`define MCID_SWI_VECTOR    10'h002
`define MCID_CTRL_MIN      4'h5

`endif

// *** logic/mcid_pkg.sv ***
package mcid_pkg;
  typedef enum logic [1:0] {
    MCID_ST_IDLE  = 2'b00,
    MCID_ST_EXEC  = 2'b01,
    MCID_ST_FLUSH = 2'b11,
    MCID_ST_SLEEP = 2'b10
  } mcid_state_e;

  typedef enum logic [3:0] {
    MCID_K_NONE  = 4'h0,
    MCID_K_MISC  = 4'h1,
    MCID_K_IOW   = 4'h2,
    MCID_K_IOR   = 4'h3,
    MCID_K_ALU   = 4'h4,
    MCID_K_MOVRA = 4'h5,
    MCID_K_CLR   = 4'h6,
    MCID_K_BIT   = 4'h7,
    MCID_K_LIT   = 4'h8,
    MCID_K_CALL  = 4'h9,
    MCID_K_JMP   = 4'hA,
    MCID_K_RET   = 4'hB,
    MCID_K_TBL   = 4'hC,
    MCID_K_SYS   = 4'hD
  } mcid_kind_e;
endpackage

// *** logic/mcid_period_timer.sv ***
`timescale 1ns/1ps
`include "mcid_regs.svh"
module mcid_period_timer (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic four_period,
  output logic      cycle_start,
  output logic      cycle_end
);
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  wire  [1:0] last_phase = four_period ? `MCID_LONG_LAST : `MCID_SHORT_LAST;

  assign cycle_start = (phase_r == 2'h0);
  assign cycle_end   = (phase_r >= last_phase);
  assign phase_nxt   = cycle_end ? 2'h0 : phase_r + 2'h1;

  always_ff @(posedge clock) begin
    if (reset) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end
endmodule // mcid_period_timer

// *** testbench/mcid_core_decode_checker.sv ***
`timescale 1ns/1ps
module mcid_core_decode_checker (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        skip_true,
  input wire logic        watchdog_timeout,
  input wire logic        fetch_strobe,
  input wire logic        timer_counter_tick,
  input wire logic        exec_valid,
  input wire logic [12:0] instr_word,
  input wire logic [5:0]  reg_sel,
  input wire logic [2:0]  bit_sel,
  input wire logic [7:0]  lit8,
  input wire logic [9:0]  pc_load_addr,
  input wire logic        pc_push,
  input wire logic        writes_pc,
  input wire logic        is_skip,
  input wire logic        upd_zero,
  input wire logic        upd_carry,
  input wire logic        upd_dcarry,
  input wire logic [3:0]  ctrl_index,
  input wire logic        ctrl_valid,
  input wire logic        sleep_instr,
  input wire logic        watchdog_clear_instr,
  input wire logic        osc_stop,
  input wire logic        time_out_flag,
  input wire logic        power_down_flag,
  input wire logic        instr_period_select
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_operand_fields: assert property (
    exec_valid |-> reg_sel == instr_word[5:0] && bit_sel == instr_word[8:6] &&
      lit8 == instr_word[7:0]) else $error("operand field mismatch");
  a_ctrl_range: assert property (
    ctrl_valid |-> ctrl_index == instr_word[3:0] &&
      ctrl_index inside {4'h5, 4'h6, 4'h7, 4'hB, 4'hE, 4'hF}) else $error("bad ctrl index");
  a_add_flags: assert property (
    exec_valid && instr_word[12:7] == 6'h07 |-> upd_zero && upd_carry && upd_dcarry)
    else $error("add flags wrong");
  a_logic_flags: assert property (
    exec_valid && instr_word[12:8] == 5'h02 |-> upd_zero && !upd_carry && !upd_dcarry)
    else $error("logic flags wrong");
  a_swi_vector: assert property (
    exec_valid && instr_word == 13'h1_E02 |-> pc_push && pc_load_addr == 10'h002)
    else $error("software interrupt vector wrong");
  a_jump_target: assert property (
    exec_valid && instr_word[12:11] == 2'h2 |-> pc_load_addr == instr_word[9:0])
    else $error("jump target wrong");
  a_pc_bubble: assert property (
    fetch_strobe && exec_valid && writes_pc && !instr_period_select |-> ##2 !exec_valid)
    else $error("no bubble after pc write");
  a_jump_bubble: assert property (
    fetch_strobe && exec_valid && instr_word[12:11] == 2'h2 && !instr_period_select
      |-> ##2 !exec_valid) else $error("no bubble after jump");
  a_skip_bubble: assert property (
    fetch_strobe && exec_valid && is_skip && skip_true && !instr_period_select
      |-> ##2 !exec_valid) else $error("no bubble after true skip");
  a_tick_four: assert property (
    timer_counter_tick && instr_period_select |=> !timer_counter_tick [*3])
    else $error("timer tick too fast");
  a_sleep_entry: assert property (
    sleep_instr |-> ##[0:4] (osc_stop && !power_down_flag)) else $error("sleep not entered");
  a_watchdog_clear_instr_flags: assert property (
    watchdog_clear_instr && !sleep_instr && !watchdog_timeout
      |-> ##[0:3] (time_out_flag && power_down_flag))
    else $error("clear watchdog flags wrong");
endmodule // mcid_core_decode_checker

bind mcid_core_decode mcid_core_decode_checker chk_u (
  .clock, .reset, .skip_true, .watchdog_timeout, .fetch_strobe, .timer_counter_tick,
  .exec_valid, .instr_word, .reg_sel, .bit_sel, .lit8, .pc_load_addr, .pc_push, .writes_pc,
  .is_skip, .upd_zero, .upd_carry, .upd_dcarry, .ctrl_index, .ctrl_valid, .sleep_instr,
  .watchdog_clear_instr, .osc_stop, .time_out_flag, .power_down_flag, .instr_period_select
);

// *** testbench/mcid_prog_mem.sv ***
`timescale 1ns/1ps
module mcid_prog_mem (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        fetch_strobe,
  input  wire logic        load_en,
  input  wire logic [5:0]  load_addr,
  input  wire logic [12:0] load_word,
  output logic      [12:0] instr_rdata
);
  logic [12:0] mem [64];
  logic [5:0]  read_ptr_r;
  always_ff @(posedge clock) begin
    if (load_en) begin
      mem[load_addr] <= load_word;
    end
  end
  // one whole 13-bit word per instruction cycle, held until the next fetch
  always_ff @(posedge clock) begin
    if (reset) begin
      read_ptr_r  <= 6'h00;
      instr_rdata <= 13'h0_000;
    end else if (fetch_strobe) begin
      instr_rdata <= mem[read_ptr_r];
      read_ptr_r  <= read_ptr_r + 6'h01;
    end
  end
endmodule // mcid_prog_mem

// *** testbench/mcid_core_decode_tb.sv ***
`timescale 1ns/1ps
module mcid_core_decode_tb;
  logic        clock, reset, skip_true, watchdog_timeout, wake_pin, load_en;
  logic [12:0] cfg_word, id_word, instr_rdata, load_word, instr_word, customer_id;
  logic [5:0]  load_addr;
  logic        fetch_strobe, timer_counter_tick, exec_valid, pc_push, keep_pc_page;
  logic        upd_zero, upd_carry, upd_dcarry, ctrl_valid, osc_stop;
  logic        time_out_flag, power_down_flag, instr_period_select, watchdog_enable;
  logic        clock_source_type, crystal_range_select, drive_power_select;
  logic        code_protect_en, cfg_reserved_err;
  logic [12:0] pw[$], ew[$], q_w[$];
  logic [5:0]  ev[$], q_v[$];
  bit          e2[$];
  int          q_c[$];
  int          cyc, n_fail, checked;

  mcid_core_decode dut_u (.clock, .reset, .cfg_word, .id_word, .instr_rdata, .skip_true,
    .watchdog_timeout, .wake_pin, .fetch_strobe, .timer_counter_tick, .exec_valid,
    .op_kind(), .instr_word, .alu_op(), .dest_is_reg(), .reg_sel(), .bit_sel(),
    .bit_action(), .lit8(), .pc_load_addr(), .pc_push, .writes_pc(), .is_skip(),
    .keep_pc_page, .upd_zero, .upd_carry, .upd_dcarry, .ctrl_index(), .ctrl_valid,
    .sleep_instr(), .watchdog_clear_instr(), .global_irq_on_instr(),
    .global_irq_off_instr(), .return_irq_instr(), .osc_stop, .time_out_flag,
    .power_down_flag, .instr_period_select, .watchdog_enable, .clock_source_type,
    .crystal_range_select, .drive_power_select, .code_protect_en, .cfg_reserved_err,
    .customer_id);
  mcid_prog_mem prog_u (.clock, .reset, .fetch_strobe, .load_en, .load_addr, .load_word,
    .instr_rdata);

  always #5 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    checked++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // log each executed non-nop word with its instruction-cycle number
  always @(posedge clock) begin
    if (reset) begin
      cyc = 0;
    end else if (fetch_strobe === 1'b1) begin
      cyc++;
      if (exec_valid === 1'b1 && instr_word !== 13'h0_000) begin
        q_w.push_back(instr_word);
        q_v.push_back({upd_zero, upd_carry, upd_dcarry, pc_push, keep_pc_page, ctrl_valid});
        q_c.push_back(cyc);
      end
    end
  end

  task automatic add(input logic [12:0] w, input logic [5:0] v, input bit two);
    pw.push_back(w);
    ew.push_back(w);
    ev.push_back(v);
    e2.push_back(two);
    if (two) begin
      pw.push_back(13'h0_080);
    end
  endtask

  task automatic restart(input logic [12:0] cfg);
    reset <= 1'b1;
    cfg_word <= cfg;
    id_word <= cfg ^ 13'h1_555;
    for (int i = 0; i < 64; i++) begin
      @(posedge clock);
      load_en <= 1'b1;
      load_addr <= i[5:0];
      load_word <= (i >= 2 && i < pw.size() + 2) ? pw[i - 2] : 13'h0_000;
    end
    @(posedge clock);
    load_en <= 1'b0;
    reset <= 1'b0;
    q_w.delete();
    q_v.delete();
    q_c.delete();
  endtask

  task automatic judge();
    check(16'(q_w.size()), 16'(ew.size()), "executed count");
    for (int i = 0; i < ew.size() && i < q_w.size(); i++) begin
      check(16'(q_w[i]), 16'(ew[i]), "word");
      check(16'(q_v[i]), 16'(ev[i]), "flag updates");
      if (i > 0) begin
        check(16'(q_c[i] - q_c[i - 1]), e2[i - 1] ? 16'h0002 : 16'h0001, "cycles");
      end
    end
  endtask

  task automatic scen_config();
    logic [12:0] cfgs [4];
    logic [12:0] c;
    int          n;
    // reserved bits kept, except in the last entry
    cfgs = '{13'h1_83D, 13'h1_987, 13'h1_910, 13'h0_83D};
    pw.delete();
    for (int k = 0; k < 4; k++) begin
      c = cfgs[k];
      restart(c);
      repeat (10) @(negedge clock);
      n = 0;
      repeat (40) begin
        @(negedge clock);
        if (timer_counter_tick === 1'b1) begin
          n++;
        end
      end
      check(16'(n), c[8] ? 16'h000A : 16'h0014, "timer ticks");
      check(16'(instr_period_select), 16'(c[8]), "period select");
      check(16'(watchdog_enable), 16'(!c[7]), "watchdog");
      check(16'(crystal_range_select), 16'(c[5] & c[4]), "crystal range");
      check(16'(clock_source_type), 16'(c[4]), "source type");
      check(16'(drive_power_select), 16'(c[3]), "drive power");
      check(16'(code_protect_en), 16'(c[2:0] != 3'h7), "protect");
      check(16'(customer_id), 16'(c ^ 13'h1_555), "customer id");
      check(16'(cfg_reserved_err), 16'(!(c[12] & c[11] & !c[9]) | (c[5] & !c[4])),
        "reserved");
    end
  endtask

  task automatic scen_stream();
    pw.delete(); ew.delete(); ev.delete(); e2.delete();
    skip_true <= 1'b1;
    add(13'h0_385, 6'h38, 0); add(13'h0_205, 6'h20, 0); add(13'h0_B83, 6'h00, 0);
    add(13'h0_E83, 6'h00, 1); add(13'h1_855, 6'h00, 0); add(13'h1_6AB, 6'h00, 1);
    add(13'h1_155, 6'h04, 1); add(13'h0_042, 6'h00, 1); add(13'h0_0C2, 6'h20, 1);
    add(13'h0_020, 6'h3A, 1); add(13'h1_E02, 6'h04, 1); add(13'h0_005, 6'h01, 0);
    add(13'h0_008, 6'h00, 0); add(13'h0_01B, 6'h01, 0); add(13'h0_545, 6'h20, 0);
    add(13'h1_D10, 6'h38, 0); add(13'h0_001, 6'h10, 0); add(13'h0_010, 6'h00, 0);
    add(13'h0_011, 6'h00, 0); add(13'h0_013, 6'h00, 1); add(13'h0_004, 6'h00, 0);
    add(13'h0_003, 6'h00, 0);
    restart(13'h1_83D);
    for (int t = 0; t < 300 && osc_stop !== 1'b1; t++) @(negedge clock);
    check(16'({osc_stop, power_down_flag, time_out_flag}), 16'h0005, "sleep");
    @(posedge clock);
    watchdog_timeout <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
    @(negedge clock);
    check(16'(time_out_flag), 16'h0000, "timeout flag");
    wake_pin <= 1'b1;
    for (int t = 0; t < 20 && osc_stop !== 1'b0; t++) @(negedge clock);
    check(16'(osc_stop), 16'h0000, "wake");
    wake_pin <= 1'b0;
    judge();
  endtask

  task automatic scen_four();
    pw.delete(); ew.delete(); ev.delete(); e2.delete();
    skip_true <= 1'b0;
    add(13'h0_E83, 6'h00, 0); add(13'h0_385, 6'h38, 0);
    add(13'h1_6AB, 6'h00, 1); add(13'h0_205, 6'h20, 0);
    restart(13'h1_907);
    repeat (80) @(negedge clock);
    judge();
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    cfg_word = 13'h1_83D;
    id_word = 13'h0_000;
    skip_true = 1'b0;
    watchdog_timeout = 1'b0;
    wake_pin = 1'b0;
    load_en = 1'b0;
    load_addr = 6'h00;
    load_word = 13'h0_000;
    n_fail = 0;
    checked = 0;
    repeat (20) @(posedge clock);
    scen_config();
    scen_stream();
    scen_four();
    close_out();
  end

  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule // mcid_core_decode_tb
